// *** core/anps_regs.sv ***
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module anps_regs (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Management register port
  input  wire logic [4:0]               reg_addr,
  input  wire logic [15:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [15:0]              reg_rdata,
  // Negotiation engine side
  input  wire anps_pkg::anps_status_in_t st_in,
  input  wire anps_pkg::anps_np_word_t  np_rx_word,
  input  wire logic                     np_rx_valid,
  input  wire logic                     np_tx_done,
  output anps_pkg::anps_np_word_t       np_tx_word,
  output logic                          np_msg_mode,
  // Interrupt
  output logic                          irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser
  logic rst_meta;
  logic rst_sync_n;

  // Async assert, synchronous release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic rd_exp;
  logic rd_ms;
  logic wr_np_tx;
  logic wr_irq_en;
  logic wr_irq_clr;

  // Read-clear strobes and write strobes
  assign rd_exp     = reg_rd && (reg_addr == anps_pkg::ADDR_EXP_STATUS);
  assign rd_ms      = reg_rd && (reg_addr == anps_pkg::ADDR_MS_STATUS);
  assign wr_np_tx   = reg_wr && (reg_addr == anps_pkg::ADDR_NP_TX);
  assign wr_irq_en  = reg_wr && (reg_addr == anps_pkg::ADDR_IRQ_ENABLE);
  assign wr_irq_clr = reg_wr && (reg_addr == anps_pkg::ADDR_IRQ_CLEAR);

  ////////////////////////////////////////////////////////////////////////////
  // Latched-high status flags
  logic pd_fault_flag;
  logic page_rx_flag;
  logic ms_fault_flag;

  // Parallel-detect fault, cleared by reading expansion status
  anps_sticky u_pd_fault (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .set   (st_in.pd_fault),
    .clr   (rd_exp),
    .flag  (pd_fault_flag)
  );

  // New page arrived; either engine pulse or stored page counts
  anps_sticky u_page_rx (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .set   (st_in.page_rx | np_rx_valid),
    .clr   (rd_exp),
    .flag  (page_rx_flag)
  );

  // Manual master/slave fault, cleared by reading master/slave status
  anps_sticky u_ms_fault (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .set   (st_in.ms_fault),
    .clr   (rd_ms),
    .flag  (ms_fault_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Idle error counter
  logic [7:0] idle_err_cnt;

  // Saturates so a burst is never hidden; a same-cycle error survives the read
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      idle_err_cnt <= 8'h00;
    end else if (rd_ms) begin
      idle_err_cnt <= st_in.idle_err ? 8'h01 : 8'h00;
    end else if (st_in.idle_err && idle_err_cnt != 8'hff) begin
      idle_err_cnt <= idle_err_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-page transmit word
  logic        tx_more;
  logic        tx_msg;
  logic        tx_comply;
  logic [10:0] tx_code;
  logic        tx_toggle_inv;

  // Writable fields; bit 14 and bit 11 ignore writes
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_more   <= 1'b0;
      tx_msg    <= 1'b0;
      tx_comply <= 1'b0;
      tx_code   <= anps_pkg::NP_TX_CODE_RST;
    end else if (wr_np_tx) begin
      tx_more   <= reg_wdata[anps_pkg::NP_MORE];
      tx_msg    <= reg_wdata[anps_pkg::NP_MSG];
      tx_comply <= reg_wdata[anps_pkg::NP_COMPLY];
      tx_code   <= reg_wdata[10:0];
    end
  end

  // Toggle flips per page sent, shown as inverse of the last one sent
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_toggle_inv <= 1'b0;
    end else if (np_tx_done) begin
      tx_toggle_inv <= ~tx_toggle_inv;
    end
  end

  // Word driven toward the partner
  always_comb begin
    np_tx_word                     = '0;
    np_tx_word.more                = tx_more;
    np_tx_word.rsvd                = 1'b0;
    np_tx_word.message_page_select = tx_msg;
    np_tx_word.message_comply_flag = tx_comply;
    np_tx_word.toggle              = tx_toggle_inv;
    np_tx_word.page_code_field     = tx_code;
  end

  // Tells the engine how to interpret the code field
  assign np_msg_mode = tx_msg;

  ////////////////////////////////////////////////////////////////////////////
  // Next-page received word
  anps_pkg::anps_np_word_t rx_word;

  // Captured whole; toggle stored inverted, reserved forced low
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_word                 <= '0;
      rx_word.page_code_field <= anps_pkg::NP_RX_CODE_RST;
    end else if (np_rx_valid) begin
      rx_word        <= np_rx_word;
      rx_word.toggle <= ~np_rx_word.toggle;
      rx_word.rsvd   <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts
  logic [anps_pkg::IRQ_WIDTH-1:0] irq_set;
  logic [anps_pkg::IRQ_WIDTH-1:0] irq_status;
  logic [anps_pkg::IRQ_WIDTH-1:0] irq_enable;

  // Event sources
  always_comb begin
    irq_set                         = '0;
    irq_set[anps_pkg::IRQ_PD_FAULT] = st_in.pd_fault;
    irq_set[anps_pkg::IRQ_PAGE_RX]  = st_in.page_rx | np_rx_valid;
    irq_set[anps_pkg::IRQ_MS_FAULT] = st_in.ms_fault;
    irq_set[anps_pkg::IRQ_IDLE_ERR] = st_in.idle_err;
  end

  // One sticky bit per event, cleared by writing ones
  genvar gi;
  generate
    for (gi = 0; gi < anps_pkg::IRQ_WIDTH; gi++) begin : g_irq
      anps_sticky u_irq (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .set   (irq_set[gi]),
        .clr   (wr_irq_clr & reg_wdata[gi]),
        .flag  (irq_status[gi])
      );
    end
  endgenerate

  // Enable mask
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_enable <= '0;
    end else if (wr_irq_en) begin
      irq_enable <= reg_wdata[anps_pkg::IRQ_WIDTH-1:0];
    end
  end

  // Level interrupt
  assign irq = |(irq_status & irq_enable);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [15:0] next_rdata;

  // Unmapped and reserved bits read zero
  always_comb begin
    next_rdata = 16'h0000;
    case (reg_addr)
      anps_pkg::ADDR_EXP_STATUS: begin
        next_rdata[anps_pkg::EXP_PD_FAULT]   = pd_fault_flag;
        next_rdata[anps_pkg::EXP_LP_NP_ABLE] = st_in.lp_np_able;
        next_rdata[anps_pkg::EXP_LOC_NP]     = anps_pkg::LOC_NP_RST;
        next_rdata[anps_pkg::EXP_PAGE_RX]    = page_rx_flag;
        next_rdata[anps_pkg::EXP_LP_AN_ABLE] = st_in.an_enable & st_in.partner_negotiation_able;
      end
      anps_pkg::ADDR_NP_TX: begin
        next_rdata = np_tx_word;
      end
      anps_pkg::ADDR_NP_RX: begin
        next_rdata = rx_word;
      end
      anps_pkg::ADDR_MS_STATUS: begin
        next_rdata[anps_pkg::MS_FAULT]    = ms_fault_flag;
        next_rdata[anps_pkg::MS_MASTER]   = st_in.ms_master;
        next_rdata[anps_pkg::MS_LOC_RX]   = st_in.loc_rx_ok;
        next_rdata[anps_pkg::MS_REM_RX]   = st_in.rem_rx_ok;
        next_rdata[anps_pkg::MS_GIG_FD]   = st_in.gig_fd_adv;
        next_rdata[anps_pkg::MS_LP_GIG_H] = st_in.lp_gig_hd;
        next_rdata[7:0]                   = idle_err_cnt;
      end
      anps_pkg::ADDR_IRQ_STATUS: begin
        next_rdata[anps_pkg::IRQ_WIDTH-1:0] = irq_status;
      end
      anps_pkg::ADDR_IRQ_ENABLE: begin
        next_rdata[anps_pkg::IRQ_WIDTH-1:0] = irq_enable;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule // anps_regs

`default_nettype wire

// *** core/anps_pkg.sv ***
package anps_pkg;

  // Register indices (word addresses on the management port)
  localparam logic [4:0] ADDR_EXP_STATUS = 5'h06;
  localparam logic [4:0] ADDR_NP_TX      = 5'h07;
  localparam logic [4:0] ADDR_NP_RX      = 5'h08;
  localparam logic [4:0] ADDR_MS_STATUS  = 5'h0a;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h18;
  localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h19;
  localparam logic [4:0] ADDR_IRQ_CLEAR  = 5'h1a;

  // Expansion status bit positions
  localparam int EXP_PD_FAULT   = 4;
  localparam int EXP_LP_NP_ABLE = 3;
  localparam int EXP_LOC_NP     = 2;
  localparam int EXP_PAGE_RX    = 1;
  localparam int EXP_LP_AN_ABLE = 0;

  // Next-page word bit positions
  localparam int NP_MORE   = 15;
  localparam int NP_RSVD   = 14;
  localparam int NP_MSG    = 13;
  localparam int NP_COMPLY = 12;
  localparam int NP_TOGGLE = 11;

  // Master/slave status bit positions
  localparam int MS_FAULT    = 15;
  localparam int MS_MASTER   = 14;
  localparam int MS_LOC_RX   = 13;
  localparam int MS_REM_RX   = 12;
  localparam int MS_GIG_FD   = 11;
  localparam int MS_LP_GIG_H = 10;

  // Reset values
  localparam logic [10:0] NP_TX_CODE_RST = 11'h001;
  localparam logic [10:0] NP_RX_CODE_RST = 11'h000;
  localparam logic        LOC_NP_RST     = 1'h1;

  // Interrupt event bit positions
  localparam int IRQ_PD_FAULT = 0;
  localparam int IRQ_PAGE_RX  = 1;
  localparam int IRQ_MS_FAULT = 2;
  localparam int IRQ_IDLE_ERR = 3;
  localparam int IRQ_WIDTH    = 4;

  // Next-page word layout
  typedef struct packed {
    logic        more;
    logic        rsvd;
    logic        message_page_select;
    logic        message_comply_flag;
    logic        toggle;
    logic [10:0] page_code_field;
  } anps_np_word_t;

  // Status inputs from negotiation and receiver logic
  typedef struct packed {
    logic pd_fault;
    logic page_rx;
    logic lp_np_able;
    logic partner_negotiation_able;
    logic an_enable;
    logic ms_fault;
    logic ms_master;
    logic loc_rx_ok;
    logic rem_rx_ok;
    logic gig_fd_adv;
    logic lp_gig_hd;
    logic idle_err;
  } anps_status_in_t;

endpackage : anps_pkg

// *** core/anps_sticky.sv ***
`timescale 1ns/1ps
`default_nettype none

// One sticky flag; a set in the same cycle as a clear wins
module anps_sticky (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic set,
  input  wire logic clr,
  // State
  output logic      flag
);

  // Set has priority so no event is lost at the clear edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end

endmodule // anps_sticky

`default_nettype wire

// *** tb/anps_regs_props.sv ***
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of the status/page register block
module anps_regs_props (
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      rst_n,
  // Register port
  input wire logic [4:0]                reg_addr,
  input wire logic [15:0]               reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [15:0]               reg_rdata,
  // Engine side
  input wire anps_pkg::anps_status_in_t st_in,
  input wire logic                      np_rx_valid,
  input wire logic                      np_tx_done,
  input wire anps_pkg::anps_np_word_t   np_tx_word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////
  // Read decode helpers
  logic rd_exp;
  logic rd_ms;
  assign rd_exp = reg_rd && reg_addr == anps_pkg::ADDR_EXP_STATUS;
  assign rd_ms  = reg_rd && reg_addr == anps_pkg::ADDR_MS_STATUS;

  ////////////////////////////////////////////////////////////////
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside read reply");
  chk_exp_fixed: assert property (rd_exp |=> reg_rdata[15:5] == 11'h000 && reg_rdata[2])
    else $error("expansion fixed bits wrong");
  chk_exp_lp_np: assert property (rd_exp |=> reg_rdata[3] == $past(st_in.lp_np_able))
    else $error("partner next page ability wrong");
  chk_exp_an_able: assert property (rd_exp |=> reg_rdata[0] ==
      $past(st_in.an_enable & st_in.partner_negotiation_able))
    else $error("partner negotiation ability wrong");
  chk_pd_fault_set: assert property (st_in.pd_fault ##1 rd_exp |=> reg_rdata[4])
    else $error("parallel fault not latched");
  chk_pd_fault_clear: assert property ((rd_exp && !st_in.pd_fault) ##1
      (rd_exp && !st_in.pd_fault) |=> !reg_rdata[4])
    else $error("parallel fault not cleared by read");
  chk_page_rx_set: assert property (np_rx_valid ##1 rd_exp |=> reg_rdata[1])
    else $error("page received not latched");
  chk_ms_levels: assert property (rd_ms |=> reg_rdata[14:8] == {$past({st_in.ms_master,
      st_in.loc_rx_ok, st_in.rem_rx_ok, st_in.gig_fd_adv, st_in.lp_gig_hd}), 2'b00})
    else $error("master/slave level bits wrong");
  chk_idle_restart: assert property ((rd_ms && !st_in.idle_err) ##1 rd_ms
      |=> reg_rdata[7:0] == 8'h00)
    else $error("idle count not restarted by read");
  chk_tx_write: assert property (reg_wr && reg_addr == anps_pkg::ADDR_NP_TX |=>
      {np_tx_word.more, np_tx_word.rsvd, np_tx_word.message_comply_flag, np_tx_word.page_code_field}
      == {$past(reg_wdata[15]), 1'b0, $past(reg_wdata[12]), $past(reg_wdata[10:0])})
    else $error("transmit word not updated by write");
  chk_toggle_flip: assert property (np_tx_done |=> np_tx_word.toggle != $past(np_tx_word.toggle))
    else $error("transmit toggle did not flip");

  // Main scenarios reached
  cov_page: cover property (np_rx_valid ##1 rd_exp);
  cov_idle: cover property (rd_ms ##1 rd_ms);
  cov_fault: cover property (st_in.pd_fault ##1 rd_exp);
endmodule // anps_regs_props

bind anps_regs anps_regs_props anps_regs_props_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .st_in(st_in),
  .np_rx_valid(np_rx_valid), .np_tx_done(np_tx_done), .np_tx_word(np_tx_word));

`default_nettype wire

// *** tb/anps_lp_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Negotiation engine plus far partner: one page exchanged per request
module anps_lp_model (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    rst_n,
  // Bench control
  input wire logic                    xfer,
  input wire logic [15:0]             page,
  output logic     [15:0]             sent_word,
  // Block side
  input wire anps_pkg::anps_np_word_t np_tx_word,
  output anps_pkg::anps_np_word_t     np_rx_word,
  output logic                        np_rx_valid,
  output logic                        np_tx_done
);
  // Page word is not held between exchanges, so it churns every cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      np_rx_word  <= '0;
      np_rx_valid <= 1'b0;
      np_tx_done  <= 1'b0;
      sent_word   <= '0;
    end else begin
      np_rx_valid <= xfer;
      np_tx_done  <= xfer;
      np_rx_word  <= xfer ? page : ~np_rx_word;
      if (xfer) begin
        sent_word <= np_tx_word;
      end
    end
  end
endmodule // anps_lp_model

`default_nettype wire

// *** tb/test_anps_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_anps_regs;
  logic                      clk = 1'b0;
  logic                      rst_n = 1'b0;
  logic [4:0]                reg_addr = '0;
  logic [15:0]               reg_wdata = '0;
  logic                      reg_wr = 1'b0;
  logic                      reg_rd = 1'b0;
  logic [15:0]               reg_rdata;
  anps_pkg::anps_status_in_t st_in = '0;
  anps_pkg::anps_np_word_t   np_rx_word;
  anps_pkg::anps_np_word_t   np_tx_word;
  logic                      np_rx_valid;
  logic                      np_tx_done;
  logic                      np_msg_mode;
  logic                      irq;
  logic                      xfer = 1'b0;
  logic [15:0]               sent_word;
  logic [15:0]               d;
  logic [15:0]               t0;
  logic [15:0]               d2;
  int                        fails = 0;
  int                        n_compared = 0;

  anps_regs anps_regs_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .st_in(st_in), .np_rx_word(np_rx_word),
    .np_rx_valid(np_rx_valid), .np_tx_done(np_tx_done), .np_tx_word(np_tx_word),
    .np_msg_mode(np_msg_mode), .irq(irq));
  anps_lp_model anps_lp_model_inst (.clk(clk), .rst_n(rst_n), .xfer(xfer), .page(16'he805),
    .sent_word(sent_word), .np_tx_word(np_tx_word), .np_rx_word(np_rx_word),
    .np_rx_valid(np_rx_valid), .np_tx_done(np_tx_done));

  ////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Reply stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Two reads with no gap; the second strobe stands while the first reply shows
  task automatic rd2(input logic [4:0] a, output logic [15:0] d1, output logic [15:0] d2x);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    #1 d1 = reg_rdata;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d2x = reg_rdata;
  endtask

  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values
    rd(5'h06); chk(d, 16'h0004);
    rd(5'h07); chk(d & 16'hf7ff, 16'h0001);
    rd(5'h08); chk(d, 16'h0000);
    rd(5'h0a); chk(d, 16'h0000);
    rd(5'h1f); chk(d, 16'h0000);
    // Writable transmit fields, reserved bit stays zero
    wr(5'h07, 16'hffff); rd(5'h07); chk(d & 16'hf7ff, 16'hb7ff);
    wr(5'h07, 16'h2005); @(posedge clk); #1 chk({15'h0, np_msg_mode}, 16'h1);
    wr(5'h07, 16'h9005);
    // Partner ability levels
    @(posedge clk); st_in.lp_np_able <= 1'b1; st_in.partner_negotiation_able <= 1'b1;
    rd(5'h06); chk(d, 16'h000c);
    @(posedge clk); st_in.an_enable <= 1'b1;
    rd(5'h06); chk(d, 16'h000d);
    // Sticky fault, read clears
    @(posedge clk); st_in.pd_fault <= 1'b1;
    @(posedge clk); st_in.pd_fault <= 1'b0;
    rd(5'h06); chk(d, 16'h001d);
    rd(5'h06); chk(d, 16'h000d);
    // Engine page pulse and fault together, then back-to-back clearing reads
    @(posedge clk);
    st_in.pd_fault <= 1'b1;
    st_in.page_rx  <= 1'b1;
    @(posedge clk);
    st_in.pd_fault <= 1'b0;
    st_in.page_rx  <= 1'b0;
    rd2(5'h06, d, d2);
    chk(d, 16'h001f);
    chk(d2, 16'h000d);
    // Page exchange: stored word, toggles and new-page flag
    rd(5'h07); t0 = d;
    @(posedge clk); xfer <= 1'b1;
    @(posedge clk); xfer <= 1'b0;
    #1 chk(sent_word & 16'hf7ff, 16'h9005);
    rd(5'h06); chk(d, 16'h000f);
    rd(5'h06); chk(d, 16'h000d);
    rd(5'h08); chk(d, 16'ha005);
    wr(5'h08, 16'hffff); rd(5'h08); chk(d, 16'ha005);
    rd(5'h07); chk({15'h0, d[11]}, {15'h0, ~t0[11]});
    // Master/slave status, saturating idle count
    @(posedge clk); st_in.ms_master <= 1'b1; st_in.loc_rx_ok <= 1'b1; st_in.ms_fault <= 1'b1;
    st_in.idle_err <= 1'b1;
    @(posedge clk); st_in.ms_fault <= 1'b0;
    repeat (300) @(posedge clk);
    st_in.idle_err <= 1'b0;
    rd(5'h0a); chk(d, 16'he0ff);
    rd(5'h0a); chk(d, 16'h6000);
    // Slave result, remote and gigabit levels, short idle count then restart
    @(posedge clk);
    st_in.ms_master  <= 1'b0;
    st_in.rem_rx_ok  <= 1'b1;
    st_in.gig_fd_adv <= 1'b1;
    st_in.lp_gig_hd  <= 1'b1;
    st_in.idle_err   <= 1'b1;
    repeat (3) @(posedge clk);
    st_in.idle_err <= 1'b0;
    rd2(5'h0a, d, d2);
    chk(d, 16'h3c03);
    chk(d2, 16'h3c00);
    // Interrupt status, enable and clear
    rd(5'h18); chk(d, 16'h000f);
    chk({15'h0, irq}, 16'h0);
    wr(5'h19, 16'h000f); @(posedge clk); #1 chk({15'h0, irq}, 16'h1);
    rd(5'h19); chk(d, 16'h000f);
    rd(5'h1a); chk(d, 16'h0000);
    wr(5'h1a, 16'h000f); @(posedge clk); #1 chk({15'h0, irq}, 16'h0);
    wr(5'h19, 16'h0001);
    @(posedge clk); xfer <= 1'b1;
    @(posedge clk); xfer <= 1'b0;
    repeat (2) @(posedge clk); #1 chk({15'h0, irq}, 16'h0);
    @(posedge clk); st_in.pd_fault <= 1'b1;
    @(posedge clk); st_in.pd_fault <= 1'b0;
    #1 chk({15'h0, irq}, 16'h1);
    end_sim();
  end
endmodule // test_anps_regs

`default_nettype wire
